// ==== rtl/sec_irq_pkg.sv ====
// Purpose: Constants for the secondary interrupt aggregator
// Assumes: 16-bit registers on a plain strobe port
// Notes: Offsets are register indices on the plain port
package sec_irq_pkg;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [15:0] OFF_PRIMARY = 16'h4010;
   localparam logic [15:0] OFF_STATUS_ONE = 16'h4011;
   localparam logic [15:0] OFF_STATUS_TWO = 16'h4012;
   localparam logic [15:0] OFF_STATUS_FIVE = 16'h4015;
   localparam logic [15:0] OFF_PRIMARY_MASK = 16'h4018;
   localparam logic [15:0] OFF_MASK_ONE = 16'h4019;
   localparam logic [15:0] OFF_MASK_TWO = 16'h401A;
   localparam logic [15:0] OFF_MASK_FIVE = 16'h401D;
   localparam logic [15:0] OFF_PIN_TRIGGER = 16'h4020;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int BIT_THERMAL = 1;
   localparam int BIT_BUTTON = 12;
   localparam int BIT_POR = 2;
   localparam int BIT_SLEEP_OFF = 1;
   localparam int BIT_ON_WAKE = 0;
   localparam int BIT_PRI_PS = 15;
   localparam int BIT_PRI_THERMAL = 14;
   localparam int BIT_PRI_PINS = 13;
   localparam int BIT_PRI_BUTTON = 12;
   localparam int PIN_COUNT = 12;
   // ----------------------------------------
   // Reset values and writable masks
   // ----------------------------------------
   localparam logic [15:0] MASK_ONE_BITS = 16'h1002;
   localparam logic [15:0] MASK_TWO_BITS = 16'h0007;
   localparam logic [15:0] MASK_FIVE_BITS = 16'h0FFF;
   localparam logic [15:0] PRIMARY_MASK_BITS = 16'hF017;
   localparam logic [15:0] PIN_TRIGGER_RESET = 16'h0000;
   // Pin trigger modes: two bits per pin
   typedef enum logic [1:0] {
      TRIG_RISE = 2'b00,
      TRIG_FALL = 2'b01,
      TRIG_BOTH = 2'b10,
      TRIG_LEVEL = 2'b11
   } trig_type;
endpackage

// ==== rtl/edge_detect.sv ====
// Purpose: Synchronise one source and report selected edge or level
// Assumes: Source may be asynchronous
// Notes: First stage is read by the second stage only
`timescale 1ns/1ps
module edge_detect
   import sec_irq_pkg::*;
(
   input wire logic core_clk, // Clock
   input wire logic rst_n, // Async reset, active low
   input wire logic srcIn, // Source condition
   input wire logic [1:0] mode, // Trigger select
   output logic hit // Event this cycle
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic prev;
   } st_type;
   st_type st_r, st_nxt;
   logic rise, fall;

   // ----------------------------------------
   // Sync and edge compare
   // ----------------------------------------
   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = srcIn;
      st_nxt.s2 = st_r.s1;
      st_nxt.prev = st_r.s2;
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Event select by mode
   assign rise = st_r.s2 & ~st_r.prev;
   assign fall = ~st_r.s2 & st_r.prev;
   always_comb begin
      case (trig_type'(mode))
         TRIG_RISE: hit = rise;
         TRIG_FALL: hit = fall;
         TRIG_BOTH: hit = rise | fall;
         TRIG_LEVEL: hit = st_r.s2;
         default: hit = 1'b0;
      endcase
   end
endmodule

// ==== rtl/secondary_interrupt_aggregator.sv ====
// Purpose: Secondary event bits, masks and primary interrupt bits
// Assumes: One clock, plain register port, sources synchronised inside
// Notes: Status bits are write-one-to-clear
`timescale 1ns/1ps
module secondary_interrupt_aggregator
   import sec_irq_pkg::*;
(
   input wire logic core_clk, // 25 MHz clock
   input wire logic rst_n, // Async reset, active low
   input wire logic [15:0] regAddr, // Register offset
   input wire logic [15:0] regWdata, // Write data
   input wire logic regWr, // Write strobe
   input wire logic regRd, // Read strobe
   output logic [15:0] regRdata, // Read data, cycle after strobe
   input wire logic powerOnReset, // Power-on-reset indication
   input wire logic sleepOffEntry, // Entered sleep or off
   input wire logic onWakeEntry, // Entered on or wake
   input wire logic thermalWarning, // Thermal warning condition
   input wire logic powerButton, // On pin level
   input wire logic [11:0] pinLevels, // General-purpose pin levels
   input wire logic [15:0] otherPrimary, // Primaries from other groups
   output logic irqOut // Host interrupt, active high
);
   typedef struct packed {
      logic [15:0] statusOne;
      logic [15:0] statusTwo;
      logic [15:0] statusFive;
      logic [15:0] maskOne;
      logic [15:0] maskTwo;
      logic [15:0] maskFive;
      logic [15:0] primaryMask;
      logic [23:0] pinTrigger;
      logic [15:0] rdata;
      logic irq;
   } st_type;
   st_type st_r, st_nxt;
   logic [15:0] evOne, evTwo, evFive, primary, clrData;
   logic thermHit, buttonHit, porHit, sleepHit, wakeHit;
   logic [11:0] pinHit;
   logic psPri, thermPri, pinPri, buttonPri;

   // ----------------------------------------
   // Source edge detectors
   // ----------------------------------------
   edge_detect u_por (.core_clk(core_clk), .rst_n(rst_n), .srcIn(powerOnReset),
      .mode(TRIG_RISE), .hit(porHit));
   edge_detect u_sleep (.core_clk(core_clk), .rst_n(rst_n), .srcIn(sleepOffEntry),
      .mode(TRIG_RISE), .hit(sleepHit));
   edge_detect u_wake (.core_clk(core_clk), .rst_n(rst_n), .srcIn(onWakeEntry),
      .mode(TRIG_RISE), .hit(wakeHit));
   edge_detect u_therm (.core_clk(core_clk), .rst_n(rst_n), .srcIn(thermalWarning),
      .mode(TRIG_BOTH), .hit(thermHit));
   edge_detect u_button (.core_clk(core_clk), .rst_n(rst_n), .srcIn(powerButton),
      .mode(TRIG_BOTH), .hit(buttonHit));

   // One detector per pin, mode from its own trigger field
   genvar gi;
   generate
      for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
         edge_detect u_pin (.core_clk(core_clk), .rst_n(rst_n), .srcIn(pinLevels[gi]),
            .mode(st_r.pinTrigger[2*gi +: 2]), .hit(pinHit[gi]));
      end
   endgenerate

   // ----------------------------------------
   // Event vectors in register layout
   // ----------------------------------------
   always_comb begin
      evOne = 16'h0000;
      evOne[BIT_THERMAL] = thermHit;
      evOne[BIT_BUTTON] = buttonHit;
      evTwo = 16'h0000;
      evTwo[BIT_POR] = porHit;
      evTwo[BIT_SLEEP_OFF] = sleepHit;
      evTwo[BIT_ON_WAKE] = wakeHit;
      evFive = {4'h0, pinHit};
   end

   // ----------------------------------------
   // Primary aggregation
   // ----------------------------------------
   assign psPri = |(st_r.statusTwo & ~st_r.maskTwo & MASK_TWO_BITS);
   assign thermPri = st_r.statusOne[BIT_THERMAL] & ~st_r.maskOne[BIT_THERMAL];
   assign pinPri = |(st_r.statusFive & ~st_r.maskFive & MASK_FIVE_BITS);
   assign buttonPri = st_r.statusOne[BIT_BUTTON] & ~st_r.maskOne[BIT_BUTTON];
   always_comb begin
      primary = otherPrimary & 16'h0FFF;
      primary[BIT_PRI_PS] = psPri;
      primary[BIT_PRI_THERMAL] = thermPri;
      primary[BIT_PRI_PINS] = pinPri;
      primary[BIT_PRI_BUTTON] = buttonPri;
   end

   // ----------------------------------------
   // Register update and read
   // ----------------------------------------
   assign clrData = regWr ? regWdata : 16'h0000;
   always_comb begin
      st_nxt = st_r;
      // Set wins over a clearing write; zeros leave bits alone
      st_nxt.statusOne = ((st_r.statusOne & ~((regAddr == OFF_STATUS_ONE) ? clrData : 16'h0000))
         | evOne) & MASK_ONE_BITS;
      st_nxt.statusTwo = ((st_r.statusTwo & ~((regAddr == OFF_STATUS_TWO) ? clrData : 16'h0000))
         | evTwo) & MASK_TWO_BITS;
      st_nxt.statusFive = ((st_r.statusFive & ~((regAddr == OFF_STATUS_FIVE) ? clrData : 16'h0000))
         | evFive) & MASK_FIVE_BITS;
      if (regWr) begin
         case (regAddr)
            OFF_MASK_ONE: st_nxt.maskOne = regWdata & MASK_ONE_BITS;
            OFF_MASK_TWO: st_nxt.maskTwo = regWdata & MASK_TWO_BITS;
            OFF_MASK_FIVE: st_nxt.maskFive = regWdata & MASK_FIVE_BITS;
            OFF_PRIMARY_MASK: st_nxt.primaryMask = regWdata & PRIMARY_MASK_BITS;
            OFF_PIN_TRIGGER: st_nxt.pinTrigger[15:0] = regWdata;
            OFF_PIN_TRIGGER + 16'h0001: st_nxt.pinTrigger[23:16] = regWdata[7:0];
            default: st_nxt.pinTrigger = st_r.pinTrigger;
         endcase
      end
      // Read mux; unmapped reads give zero
      st_nxt.rdata = 16'h0000;
      if (regRd) begin
         case (regAddr)
            OFF_PRIMARY: st_nxt.rdata = primary;
            OFF_STATUS_ONE: st_nxt.rdata = st_r.statusOne;
            OFF_STATUS_TWO: st_nxt.rdata = st_r.statusTwo;
            OFF_STATUS_FIVE: st_nxt.rdata = st_r.statusFive;
            OFF_MASK_ONE: st_nxt.rdata = st_r.maskOne;
            OFF_MASK_TWO: st_nxt.rdata = st_r.maskTwo;
            OFF_MASK_FIVE: st_nxt.rdata = st_r.maskFive;
            OFF_PRIMARY_MASK: st_nxt.rdata = st_r.primaryMask;
            OFF_PIN_TRIGGER: st_nxt.rdata = st_r.pinTrigger[15:0];
            OFF_PIN_TRIGGER + 16'h0001: st_nxt.rdata = {8'h00, st_r.pinTrigger[23:16]};
            default: st_nxt.rdata = 16'h0000;
         endcase
      end
      st_nxt.irq = |(primary & ~st_r.primaryMask);
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r.statusOne <= 16'h0000;
         st_r.statusTwo <= 16'h0000;
         st_r.statusFive <= 16'h0000;
         st_r.maskOne <= MASK_ONE_BITS;
         st_r.maskTwo <= MASK_TWO_BITS;
         st_r.maskFive <= MASK_FIVE_BITS;
         st_r.primaryMask <= PRIMARY_MASK_BITS;
         st_r.pinTrigger <= {PIN_TRIGGER_RESET, 8'h00};
         st_r.rdata <= 16'h0000;
         st_r.irq <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign regRdata = st_r.rdata;
   assign irqOut = st_r.irq;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   sequence clearOne_s;
      regWr && regAddr == OFF_STATUS_ONE && regWdata[BIT_THERMAL] && !thermHit;
   endsequence

   chk_clear_thermal: assert property (clearOne_s |=> !st_r.statusOne[BIT_THERMAL])
      else $error("thermal bit not cleared by write one");
   chk_event_wins: assert property (porHit |=> st_r.statusTwo[BIT_POR])
      else $error("power-on-reset event lost");
   chk_zero_keeps: assert property ((regWr && regAddr == OFF_STATUS_FIVE && !regWdata[0]
      && st_r.statusFive[0]) |=> st_r.statusFive[0])
      else $error("write zero cleared a pin bit");
   chk_masked_quiet: assert property ((st_r.maskTwo == MASK_TWO_BITS) |-> !psPri)
      else $error("masked power-state event reached primary");
   chk_ps_primary: assert property (psPri == |(st_r.statusTwo & ~st_r.maskTwo))
      else $error("power-state primary wrong");
   chk_irq_gate: assert property ((primary & ~st_r.primaryMask) == 16'h0000 |=> !irqOut)
      else $error("interrupt raised while all primaries masked");
   chk_pin_primary: assert property (pinPri == |(st_r.statusFive[11:0] & ~st_r.maskFive[11:0]))
      else $error("pin primary wrong");
   chk_read_latency: assert property ((regRd && regAddr == OFF_MASK_TWO) ##1 1'b1
      |-> regRdata == $past(st_r.maskTwo))
      else $error("mask two read wrong");
   chk_button_both: assert property (buttonHit |=> st_r.statusOne[BIT_BUTTON])
      else $error("button edge not recorded");
   chk_thermal_edge: assert property (thermHit |=> st_r.statusOne[BIT_THERMAL])
      else $error("thermal edge not recorded");
   chk_pin_event: assert property ((pinHit != 12'h000) |=> (st_r.statusFive[11:0] != 12'h000))
      else $error("pin event not recorded");
endmodule

// ==== sim/host_model.sv ====
// Purpose: Host processor on the register port
// Assumes: One clock, strobes change just after a rising edge
// Notes: Each read notes its expected data in expQ for the bench
`timescale 1ns/1ps
module host_model (
   input wire logic core_clk, // Clock
   output logic [15:0] regAddr, // Register offset
   output logic [15:0] regWdata, // Write data
   output logic regWr, // Write strobe
   output logic regRd // Read strobe
);
   logic [15:0] expQ[$];
   // ----------------------------------------
   // Bus cycles
   // ----------------------------------------
   // Idle bus at time zero
   initial begin
      regAddr = 16'h0000;
      regWdata = 16'h0000;
      regWr = 1'b0;
      regRd = 1'b0;
   end
   // One write cycle; clearing status means writing ones here
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge core_clk);
      regWr <= 1'b0;
      regWdata <= ~d; // Released data no longer holds its value
   endtask
   // One read cycle with its expected data noted
   task automatic rd(input logic [15:0] a, input logic [15:0] e);
      @(posedge core_clk);
      expQ.push_back(e);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge core_clk);
      regRd <= 1'b0;
   endtask
endmodule

// ==== sim/secondary_interrupt_aggregator_test.sv ====
// Purpose: Self-checking bench for the secondary interrupt aggregator
// Assumes: Host model drives the register port
// Notes: Read data are checked by a monitor against noted values
`timescale 1ns/1ps
module secondary_interrupt_aggregator_test;
   import sec_irq_pkg::*;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [15:0] regAddr, regWdata, regRdata, otherPrimary = 16'h0000;
   logic regWr, regRd, irqOut, rdWas = 1'b0;
   logic [2:0] psSrc = 3'b000;
   logic [1:0] edgeSrc = 2'b00;
   logic [11:0] pinLevels = 12'h000;
   int errorCnt = 0;
   int compares = 0;
   int cycles = 0;
   int p;
   logic [15:0] sb, pb;
   int ob[4] = '{4, 2, 1, 0};
   logic [15:0] ra[7] = '{OFF_MASK_ONE, OFF_MASK_TWO, OFF_MASK_FIVE, OFF_PRIMARY_MASK, OFF_STATUS_ONE,
      OFF_STATUS_FIVE, 16'h4030};
   logic [15:0] rv[7] = '{MASK_ONE_BITS, MASK_TWO_BITS, MASK_FIVE_BITS, PRIMARY_MASK_BITS, 16'h0000,
      16'h0000, 16'h0000};
   // Clock
   always #20 core_clk = ~core_clk;
   host_model u_host_model (.core_clk(core_clk), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
      .regRd(regRd));
   secondary_interrupt_aggregator u_secondary_interrupt_aggregator (.core_clk(core_clk), .rst_n(rst_n),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .powerOnReset(psSrc[2]), .sleepOffEntry(psSrc[1]), .onWakeEntry(psSrc[0]),
      .thermalWarning(edgeSrc[0]), .powerButton(edgeSrc[1]), .pinLevels(pinLevels),
      .otherPrimary(otherPrimary), .irqOut(irqOut));
   // ----------------------------------------
   // Checking
   // ----------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         errorCnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chkIrq(input logic e);
      #1;
      chk({15'h0000, irqOut}, {15'h0000, e});
   endtask
   task automatic settle;
      repeat (6) @(posedge core_clk);
   endtask
   task automatic results;
      $display("errors=%0d compares=%0d", errorCnt, compares);
      if (errorCnt == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Read data stand in the cycle after the strobe
   always @(posedge core_clk) rdWas <= regRd;
   always @(negedge core_clk) begin
      if (rdWas) begin
         chk(regRdata, u_host_model.expQ.pop_front());
      end
   end
   // Hang guard
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         errorCnt++;
         results;
      end
   end
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      void'($urandom(54188));
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 7; i++) u_host_model.rd(ra[i], rv[i]);
      chkIrq(1'b0);
      $display("reset values done");
      for (int i = 0; i < 3; i++) begin
         sb = 16'h0001 << i;
         @(posedge core_clk) psSrc[i] <= 1'b1;
         settle;
         u_host_model.rd(OFF_STATUS_TWO, sb);
         u_host_model.rd(OFF_PRIMARY, 16'h0000);
         u_host_model.wr(OFF_MASK_TWO, MASK_TWO_BITS & ~sb);
         settle;
         chkIrq(1'b0);
         u_host_model.wr(OFF_PRIMARY_MASK, 16'h7017);
         u_host_model.wr(OFF_PRIMARY, 16'h0000);
         u_host_model.rd(OFF_PRIMARY, 16'h8000);
         chkIrq(1'b1);
         u_host_model.wr(OFF_STATUS_TWO, ~sb);
         u_host_model.rd(OFF_STATUS_TWO, sb);
         u_host_model.wr(OFF_STATUS_TWO, sb);
         @(posedge core_clk) psSrc[i] <= 1'b0;
         settle;
         u_host_model.rd(OFF_STATUS_TWO, 16'h0000);
         u_host_model.rd(OFF_PRIMARY, 16'h0000);
         u_host_model.wr(OFF_MASK_TWO, MASK_TWO_BITS);
         u_host_model.wr(OFF_PRIMARY_MASK, PRIMARY_MASK_BITS);
      end
      $display("power state done");
      for (int j = 0; j < 2; j++) begin
         sb = (j == 1) ? 16'h1000 : 16'h0002;
         pb = (j == 1) ? 16'h1000 : 16'h4000;
         u_host_model.wr(OFF_MASK_ONE, MASK_ONE_BITS & ~sb);
         u_host_model.wr(OFF_PRIMARY_MASK, PRIMARY_MASK_BITS & ~pb);
         for (int k = 0; k < 2; k++) begin
            @(posedge core_clk) edgeSrc[j] <= (k == 0);
            settle;
            u_host_model.rd(OFF_STATUS_ONE, sb);
            u_host_model.rd(OFF_PRIMARY, pb);
            u_host_model.wr(OFF_STATUS_ONE, sb);
            settle;
            chkIrq(1'b0);
         end
      end
      u_host_model.wr(OFF_PRIMARY_MASK, PRIMARY_MASK_BITS);
      $display("thermal and button done");
      p = $urandom_range(11, 0);
      pb = 16'h0001 << p;
      for (int m = 3; m >= 0; m--) begin
         u_host_model.wr(OFF_PIN_TRIGGER, {8{m[1:0]}});
         u_host_model.wr(OFF_PIN_TRIGGER + 16'h0001, {8'h00, {4{m[1:0]}}});
         @(posedge core_clk) pinLevels[p] <= 1'b1;
         settle;
         u_host_model.rd(OFF_STATUS_FIVE, (m != 1) ? pb : 16'h0000);
         u_host_model.wr(OFF_STATUS_FIVE, pb);
         settle;
         u_host_model.rd(OFF_STATUS_FIVE, (m == 3) ? pb : 16'h0000);
         @(posedge core_clk) pinLevels[p] <= 1'b0;
         settle;
         u_host_model.rd(OFF_STATUS_FIVE, (m != 0) ? pb : 16'h0000);
         u_host_model.wr(OFF_STATUS_FIVE, pb);
      end
      u_host_model.wr(OFF_MASK_FIVE, MASK_FIVE_BITS & ~pb);
      u_host_model.wr(OFF_PRIMARY_MASK, 16'hD017);
      @(posedge core_clk) pinLevels[p] <= 1'b1;
      settle;
      u_host_model.rd(OFF_PRIMARY, 16'h2000);
      chkIrq(1'b1);
      u_host_model.wr(OFF_PRIMARY_MASK, PRIMARY_MASK_BITS);
      $display("pin group done");
      for (int b = 0; b < 4; b++) begin
         @(posedge core_clk) otherPrimary <= 16'h0001 << ob[b];
         settle;
         chkIrq(1'b0);
         u_host_model.wr(OFF_PRIMARY_MASK, PRIMARY_MASK_BITS & ~(16'h0001 << ob[b]));
         settle;
         chkIrq(1'b1);
         u_host_model.wr(OFF_PRIMARY_MASK, PRIMARY_MASK_BITS);
      end
      $display("primary masks done");
      settle;
      results;
   end
endmodule
